// [fetpm_defs.svh]
// constants of the fast ethernet transmit pcs and mii block
`ifndef FETPM_DEFS_SVH
`define FETPM_DEFS_SVH
`define FETPM_PH_LAST 3'h4
`define FETPM_CLK_HI_PH 3'h2
`define FETPM_RX_OUT_PH 3'h1
`define FETPM_C0 5'h1E
`define FETPM_C1 5'h09
`define FETPM_C2 5'h14
`define FETPM_C3 5'h15
`define FETPM_C4 5'h0A
`define FETPM_C5 5'h0B
`define FETPM_C6 5'h0E
`define FETPM_C7 5'h0F
`define FETPM_C8 5'h12
`define FETPM_C9 5'h13
`define FETPM_CA 5'h16
`define FETPM_CB 5'h17
`define FETPM_CC 5'h1A
`define FETPM_CD 5'h1B
`define FETPM_CE 5'h1C
`define FETPM_CF 5'h1D
`define FETPM_SYM_IDLE 5'h1F
`define FETPM_SYM_J 5'h18
`define FETPM_SYM_K 5'h11
`define FETPM_SYM_T 5'h0D
`define FETPM_SYM_R 5'h07
`define FETPM_SYM_H 5'h04
`define FETPM_JK_PAIR 10'h311
`define FETPM_PREAMBLE_NIB 4'h5
`define FETPM_PRE_CNT 2'h2
`define FETPM_LFSR_SEED 11'h7FF
`define FETPM_TAP_A 10
`define FETPM_TAP_B 8
`define FETPM_LOCK_CNT 6'h28
`define FETPM_MLT_POS 2'h1
`define FETPM_MLT_NEG 2'h3
`endif

// [fetpm_pkg.sv]
// types of the fast ethernet transmit pcs and mii block
`default_nettype none
package fetpm_pkg;
	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] d;
	} fetpm_mii_tx_t;
	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
	} fetpm_rx_nib_t;
	typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fetpm_tx_st_t;
	typedef enum logic [1:0] {RX_HUNT, RX_FRAME, RX_END} fetpm_rx_st_t;
endpackage
`default_nettype wire

// [fetpm_code.sv]
// 4b5b code table: nibble to code group and code group back to nibble
`timescale 1ns/1ps
`default_nettype none
`include "fetpm_defs.svh"
module fetpm_code (
	input wire logic [3:0] nib_i,
	output logic [4:0] code_o,
	input wire logic [4:0] grp_i,
	output logic [3:0] dec_nib_o,
	output logic dec_data_o
);
	localparam logic [4:0] CODE_TBL [16] = '{`FETPM_C0, `FETPM_C1, `FETPM_C2, `FETPM_C3,
		`FETPM_C4, `FETPM_C5, `FETPM_C6, `FETPM_C7, `FETPM_C8, `FETPM_C9, `FETPM_CA,
		`FETPM_CB, `FETPM_CC, `FETPM_CD, `FETPM_CE, `FETPM_CF};
	logic [15:0] hit;
	assign code_o = CODE_TBL[nib_i];
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_dec
			assign hit[gi] = (grp_i == CODE_TBL[gi]);
		end
	endgenerate
	assign dec_data_o = |hit;
	always_comb begin
		dec_nib_o = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (hit[i]) begin
				dec_nib_o = 4'(i);
			end
		end
	end
endmodule
`default_nettype wire

// [fetpm_top.sv]
// 100 mbps pcs: mii nibbles to scrambled mlt-3 line and line back to mii
`timescale 1ns/1ps
`default_nettype none
`include "fetpm_defs.svh"
// Summary of operation
// - TXER during TXEN after the J/K nibbles sends an error symbol inside the frame.
// - each receive period with RXDV high carries one nibble on RXD.
// - receive clock runs continuously as reference for RXD, RXDV, RXER.
// - RXDV starts by the start delimiter and never covers the end delimiter.
// - a detected receive error raises RXER for at least one period.
// - carrier sense high while transmit or receive busy, low when both idle.
// - nibbles taken at 25 MHz, line logic on 125 MHz.
// - transmit makes a scrambled serial stream at 125 Msymbol/s.
// - first preamble byte becomes J then K.
// - later preamble and data nibbles become their code groups.
// - nibbles 0 to 7 map to their listed code groups.
// - nibbles 8 to F map to their listed code groups.
// - transmit enable falling appends T then R.
// - idle groups follow until transmit enable returns.
// - a bypass input skips 4b5b conversion.
// - scrambler keystream XORed with code group bits.
// - scrambled groups shifted out one bit at a time.
// - serial stream NRZI coded, toggling on each one.
// - MLT-3 makes two streams with alternating one events.
// - receive path turns serial line data back into nibbles.
// - one nibble accepted per transmit period with transmit enable high.
// - receive groups aligned on J/K, boundary fixed afterward.
// - J/K replaced by two preamble nibbles, T/R stripped.
module fetpm_top (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic [3:0] TXD_I,
	input wire logic TXEN_I,
	input wire logic TXER_I,
	input wire logic BYPASS_I,
	input wire logic LINECLK_I,
	input wire logic LINEDAT_I,
	output logic TXCLK_O,
	output logic RXCLK_O,
	output logic [3:0] RXD_O,
	output logic RXDV_O,
	output logic RXER_O,
	output logic CRS_O,
	output logic TXP_O,
	output logic TXN_O
);
	import fetpm_pkg::*;

	// nibble phase and derived mii clocks
	logic [2:0] ph_r;
	logic [2:0] ph_nxt;
	logic load;
	logic rx_take;
	assign load = (ph_r == `FETPM_PH_LAST);
	assign rx_take = (ph_r == `FETPM_RX_OUT_PH);
	assign ph_nxt = load ? 3'h0 : ph_r + 3'h1;
	// divide by five for 25 MHz
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			// parked on the last phase so the first clock high after reset is full length
			ph_r <= `FETPM_PH_LAST;
			TXCLK_O <= 1'b0;
			RXCLK_O <= 1'b0;
		end else begin
			ph_r <= ph_nxt;
			TXCLK_O <= (ph_nxt < `FETPM_CLK_HI_PH);
			RXCLK_O <= (ph_nxt < `FETPM_CLK_HI_PH);
		end
	end

	// pin synchronisers
	fetpm_mii_tx_t tx_s1_r, txs;
	logic byp_s1_r, byp_r;
	logic lc_s1_r, lc_s2_r, lc_s3_r, ld_s1_r, ld_s2_r;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			tx_s1_r <= '0;
			txs <= '0;
			byp_s1_r <= 1'b0;
			byp_r <= 1'b0;
			lc_s1_r <= 1'b0;
			lc_s2_r <= 1'b0;
			lc_s3_r <= 1'b0;
			ld_s1_r <= 1'b0;
			ld_s2_r <= 1'b0;
		end else begin
			tx_s1_r <= '{en: TXEN_I, er: TXER_I, d: TXD_I};
			txs <= tx_s1_r;
			byp_s1_r <= BYPASS_I;
			byp_r <= byp_s1_r;
			lc_s1_r <= LINECLK_I;
			lc_s2_r <= lc_s1_r;
			lc_s3_r <= lc_s2_r;
			ld_s1_r <= LINEDAT_I;
			ld_s2_r <= ld_s1_r;
		end
	end

	// transmit symbol selection
	fetpm_tx_st_t tx_st_r, tx_st_nxt;
	logic [4:0] enc_code, sym, sh_r;
	logic [4:0] rx_grp;
	logic [3:0] dec_nib;
	logic dec_data;
	fetpm_code u_code (
		.nib_i(txs.d),
		.code_o(enc_code),
		.grp_i(rx_grp),
		.dec_nib_o(dec_nib),
		.dec_data_o(dec_data)
	);
	// MAC launches on the rising edge; at phase four the nibble has cleared both sync stages
	always_comb begin
		tx_st_nxt = tx_st_r;
		sym = `FETPM_SYM_IDLE;
		unique case (tx_st_r)
			TX_IDLE: begin
				// raw five bit groups, no delimiters
				if (byp_r) begin
					sym = txs.en ? {txs.er, txs.d} : `FETPM_SYM_IDLE;
				end else if (txs.en) begin
					sym = `FETPM_SYM_J;
					tx_st_nxt = TX_K;
				end
			end
			TX_K: begin
				sym = `FETPM_SYM_K;
				tx_st_nxt = TX_DATA;
			end
			TX_DATA: begin
				if (txs.en) begin
					sym = txs.er ? `FETPM_SYM_H : enc_code;
				end else begin
					sym = `FETPM_SYM_T;
					tx_st_nxt = TX_R;
				end
			end
			TX_R: begin
				sym = `FETPM_SYM_R;
				tx_st_nxt = TX_IDLE;
			end
		endcase
	end

	// serialise, scramble, nrzi, mlt-3
	logic [10:0] tl_r;
	logic ks, scr_bit, tx_lvl_r;
	logic [1:0] mlt_r, mlt_nxt;
	// x^11 + x^9 + 1 keystream
	assign ks = tl_r[`FETPM_TAP_A] ^ tl_r[`FETPM_TAP_B];
	assign scr_bit = sh_r[4] ^ ks;
	// each one advances the three level walk
	assign mlt_nxt = scr_bit ? mlt_r + 2'h1 : mlt_r;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			tx_st_r <= TX_IDLE;
			sh_r <= `FETPM_SYM_IDLE;
			tl_r <= `FETPM_LFSR_SEED;
			tx_lvl_r <= 1'b0;
			mlt_r <= 2'h0;
			TXP_O <= 1'b0;
			TXN_O <= 1'b0;
		end else begin
			if (load) begin
				tx_st_r <= tx_st_nxt;
				sh_r <= sym;
			// msb first, one bit per clock
			end else begin
				sh_r <= {sh_r[3:0], 1'b0};
			end
			// one symbol bit per 125 MHz clock
			tl_r <= {tl_r[9:0], ks};
			tx_lvl_r <= tx_lvl_r ^ scr_bit;
			mlt_r <= mlt_nxt;
			TXP_O <= (mlt_nxt == `FETPM_MLT_POS);
			TXN_O <= (mlt_nxt == `FETPM_MLT_NEG);
		end
	end

	// receive: nrzi to nrz and descramble on each rising line clock edge
	logic ledge, nrz, pred, plain, locked;
	logic lvl_prev_r;
	logic [10:0] rl_r;
	logic [5:0] lock_cnt_r;
	assign ledge = lc_s2_r & ~lc_s3_r;
	assign nrz = ld_s2_r ^ lvl_prev_r;
	assign pred = rl_r[`FETPM_TAP_A] ^ rl_r[`FETPM_TAP_B];
	assign locked = (lock_cnt_r == `FETPM_LOCK_CNT);
	assign plain = nrz ^ pred;
	// idle is all ones, so while unlocked the inverted line bits are the keystream itself
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			lvl_prev_r <= 1'b0;
			rl_r <= 11'h000;
			lock_cnt_r <= 6'h00;
		end else if (ledge) begin
			lvl_prev_r <= ld_s2_r;
			if (locked) begin
				rl_r <= {rl_r[9:0], pred};
			end else begin
				rl_r <= {rl_r[9:0], ~nrz};
				lock_cnt_r <= (pred == ~nrz) ? lock_cnt_r + 6'h01 : 6'h00;
			end
		end
	end

	// alignment and decode
	fetpm_rx_st_t rx_st_r;
	logic [9:0] hist_r;
	logic [2:0] bcnt_r;
	logic step, jk_hit, grp_done;
	logic [1:0] pre_cnt_r;
	fetpm_rx_nib_t slot_r;
	logic slot_new;
	fetpm_rx_nib_t slot_val;
	assign step = ledge & locked;
	// J/K seen on any bit boundary
	assign jk_hit = step && (rx_st_r == RX_HUNT) && ({hist_r[8:0], plain} == `FETPM_JK_PAIR);
	assign grp_done = step && (rx_st_r != RX_HUNT) && (bcnt_r == `FETPM_PH_LAST);
	assign rx_grp = {hist_r[3:0], plain};
	assign slot_new = grp_done && (rx_st_r == RX_FRAME) && (rx_grp != `FETPM_SYM_T);
	// invalid, H or idle inside a frame flags an error
	assign slot_val = '{dv: 1'b1, er: ~dec_data, d: dec_nib};
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			rx_st_r <= RX_HUNT;
			hist_r <= 10'h000;
			bcnt_r <= 3'h0;
		end else if (step) begin
			hist_r <= {hist_r[8:0], plain};
			bcnt_r <= (jk_hit || bcnt_r == `FETPM_PH_LAST) ? 3'h0 : bcnt_r + 3'h1;
			if (jk_hit) begin
				rx_st_r <= RX_FRAME;
			end else if (grp_done) begin
				unique case (rx_st_r)
					RX_FRAME: begin
						// T and the following R are stripped
						if (rx_grp == `FETPM_SYM_T) begin
							rx_st_r <= RX_END;
						end else if (rx_grp == `FETPM_SYM_IDLE) begin
							rx_st_r <= RX_HUNT;
						end
					end
					RX_END: rx_st_r <= RX_HUNT;
					default: rx_st_r <= RX_HUNT;
				endcase
			end
		end
	end

	// mii receive outputs, changed on the falling edge of the receive clock
	logic take_pre, take_slot;
	assign take_pre = rx_take && (pre_cnt_r != 2'h0);
	assign take_slot = rx_take && !take_pre && slot_r.dv;
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			pre_cnt_r <= 2'h0;
			slot_r <= '0;
			RXD_O <= 4'h0;
			RXDV_O <= 1'b0;
			RXER_O <= 1'b0;
			CRS_O <= 1'b0;
		end else begin
			// two preamble nibbles stand in for J/K
			if (jk_hit) begin
				pre_cnt_r <= `FETPM_PRE_CNT;
			end else if (take_pre) begin
				pre_cnt_r <= pre_cnt_r - 2'h1;
			end
			// a new group wins over the slot being drained
			if (slot_new) begin
				slot_r <= slot_val;
			end else if (take_slot) begin
				slot_r <= '0;
			end
			if (rx_take) begin
				// valid from the stand-in preamble, never over T/R
				RXDV_O <= take_pre | take_slot;
				RXER_O <= take_slot & slot_r.er;
				RXD_O <= take_pre ? `FETPM_PREAMBLE_NIB : (take_slot ? slot_r.d : 4'h0);
			end
			CRS_O <= txs.en || (tx_st_r != TX_IDLE) || (rx_st_r == RX_FRAME) || (pre_cnt_r != 2'h0)
				|| slot_r.dv;
		end
	end

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SRST_I);
	AST_TXCLK_PERIOD: assert property ($rose(TXCLK_O) |=> !$rose(TXCLK_O) [*4] ##1 $rose(TXCLK_O))
		else $error("transmit clock period not five cycles");
	AST_RXCLK_PERIOD: assert property ($rose(RXCLK_O) |=> !$rose(RXCLK_O) [*4] ##1 $rose(RXCLK_O))
		else $error("receive clock not continuous");
	AST_J_START: assert property (load && tx_st_r == TX_IDLE && txs.en && !byp_r |=> sh_r == `FETPM_SYM_J)
		else $error("frame start did not send J");
	AST_K_NEXT: assert property (load && tx_st_r == TX_K |=> sh_r == `FETPM_SYM_K ##4 tx_st_r == TX_DATA)
		else $error("K missing after J");
	AST_END_TR: assert property (load && tx_st_r == TX_DATA && !txs.en |=> sh_r == `FETPM_SYM_T ##5 sh_r == `FETPM_SYM_R)
		else $error("end delimiter pair wrong");
	AST_IDLE_FILL: assert property (load && tx_st_r == TX_IDLE && !txs.en |=> sh_r == `FETPM_SYM_IDLE)
		else $error("idle fill missing");
	AST_TXER_H: assert property (load && tx_st_r == TX_DATA && txs.en && txs.er |=> sh_r == `FETPM_SYM_H)
		else $error("coding error not sent");
	AST_NRZI: assert property (1'b1 |=> (tx_lvl_r != $past(tx_lvl_r)) == $past(scr_bit))
		else $error("nrzi level did not follow ones");
	AST_MLT_EXCL: assert property (!(TXP_O && TXN_O))
		else $error("both mlt-3 streams high");
	AST_JK_PRE: assert property (jk_hit |=> pre_cnt_r == `FETPM_PRE_CNT)
		else $error("preamble not substituted");
	AST_RXER_IN_FRAME: assert property (RXER_O |-> RXDV_O)
		else $error("receive error outside frame");
	AST_CRS_TX: assert property (tx_st_r != TX_IDLE |=> CRS_O)
		else $error("carrier sense low while sending");
	COV_TX_FRAME: cover property (tx_st_r == TX_DATA ##1 tx_st_r == TX_R);
	COV_TXER: cover property (load && tx_st_r == TX_DATA && txs.en && txs.er);
	COV_RX_SFD: cover property (jk_hit);
	COV_RX_ERR: cover property (RXER_O);
endmodule
`default_nettype wire

// [fetpm_mac_model.sv]
// mac and line source model facing the pcs block
`timescale 1ns/1ps
`default_nettype none
module fetpm_mac_model (
	input wire logic txclk_i,
	output logic [3:0] txd_o,
	output logic txen_o,
	output logic txer_o,
	output logic lclk_o,
	output logic ldat_o
);
	logic [10:0] l = 11'h7FF;
	initial begin
		txd_o = 4'h0;
		txen_o = 1'b0;
		txer_o = 1'b0;
		lclk_o = 1'b0;
		ldat_o = 1'b0;
	end
	task nib(input logic en, input logic er, input logic [3:0] d);
		@(posedge txclk_i);
		#1;
		txen_o = en;
		txer_o = er;
		txd_o = d;
	endtask
	task grp(input logic [4:0] g);
		logic k;
		for (int i = 4; i >= 0; i--) begin
			k = l[10] ^ l[8];
			l = {l[9:0], k};
			ldat_o = ldat_o ^ g[i] ^ k;
			#40 lclk_o = ~lclk_o;
			#40 lclk_o = ~lclk_o;
		end
	endtask
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench of the pcs block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fetpm_pkg::*;
	localparam logic [4:0] CT [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic bypass = 1'b0;
	logic [3:0] txd, rxd;
	logic txen, txer, lclk, ldat, txclk, rxclk, rxdv, rxer, crs, txp, txn;
	int num_errors = 0;
	int comparisons = 0;
	fetpm_top fetpm_top_i (.CLK_I(clk), .SRST_I(srst), .TXD_I(txd), .TXEN_I(txen), .TXER_I(txer),
		.BYPASS_I(bypass), .LINECLK_I(lclk), .LINEDAT_I(ldat), .TXCLK_O(txclk), .RXCLK_O(rxclk),
		.RXD_O(rxd), .RXDV_O(rxdv), .RXER_O(rxer), .CRS_O(crs), .TXP_O(txp), .TXN_O(txn));
	fetpm_mac_model fetpm_mac_model_i (.txclk_i(txclk), .txd_o(txd), .txen_o(txen), .txer_o(txer),
		.lclk_o(lclk), .ldat_o(ldat));
	initial begin
		forever #4 clk = ~clk;
	end
	logic [1:0] pv = 2'h0;
	logic [10:0] ml = 11'h0;
	logic [9:0] win = 10'h0;
	logic in_frm = 1'b0;
	logic last_p = 1'b0;
	int bitn = 0;
	int lk = 0;
	int zeros = 0;
	int alt_err = 0;
	int rxclk_n = 0;
	logic [4:0] gq [$];
	logic [4:0] rq [$];
	// line monitor: mlt-3 steps give scrambled bits
	always @(posedge clk) begin : mon
		logic s, k, p;
		s = ({txp, txn} != pv);
		if (txp && !pv[1]) begin
			if (last_p) alt_err++;
			last_p = 1'b1;
		end
		if (txn && !pv[0]) begin
			if (!last_p) alt_err++;
			last_p = 1'b0;
		end
		pv = {txp, txn};
		k = ml[10] ^ ml[8];
		p = s ^ k;
		win = {win[8:0], p};
		// self-sync on idle before free running
		ml = {ml[9:0], (lk < 20) ? ~s : k};
		lk = srst ? 0 : lk + 1;
		if (!in_frm && !p) zeros++;
		if (in_frm && ++bitn % 5 == 0) begin
			gq.push_back(win[4:0]);
			if (win[4:0] == 5'h07) in_frm = 1'b0;
		end else if (!in_frm && win == 10'h311) begin
			in_frm = 1'b1;
			bitn = 0;
			gq = '{5'h18, 5'h11};
		end
	end
	always @(posedge rxclk) begin
		rxclk_n++;
		if (rxdv) rq.push_back({rxer, rxd});
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic waitq(input int n);
		for (int c = 0; c < 3000 && gq.size() < n; c++) @(posedge clk);
	endtask
	task automatic tx_check(input string what, input logic [4:0] ex [$]);
		waitq(ex.size());
		zeros = 0;
		repeat (100) @(posedge clk);
		chk(what, ex.size(), gq.size());
		foreach (ex[i]) chk(what, ex[i], gq[i]);
		chk("idle zeros", 0, zeros);
		chk("mlt3 alternation", 0, alt_err);
		chk("crs idle", 0, crs);
	endtask
	task automatic test_tx();
		logic [4:0] ex [$];
		ex = '{5'h18, 5'h11};
		fetpm_mac_model_i.nib(1, 0, 4'h5);
		fetpm_mac_model_i.nib(1, 0, 4'h5);
		for (int n = 0; n < 16; n++) begin
			fetpm_mac_model_i.nib(1, 0, n[3:0]);
			ex.push_back(CT[n]);
		end
		chk("crs tx", 1, crs);
		fetpm_mac_model_i.nib(1, 1, 4'h0);
		fetpm_mac_model_i.nib(0, 0, 4'h0);
		ex = {ex, 5'h04, 5'h0D, 5'h07};
		tx_check("tx group", ex);
		$display("test_tx done");
	endtask
	task automatic test_bypass();
		// stale groups of the last frame must not satisfy the wait
		gq.delete();
		@(posedge clk);
		#1 bypass = 1'b1;
		fetpm_mac_model_i.nib(1, 1, 4'h8);
		fetpm_mac_model_i.nib(1, 1, 4'h1);
		fetpm_mac_model_i.nib(1, 0, 4'h5);
		fetpm_mac_model_i.nib(1, 0, 4'hD);
		fetpm_mac_model_i.nib(1, 0, 4'h7);
		fetpm_mac_model_i.nib(0, 0, 4'h0);
		tx_check("bypass group", '{5'h18, 5'h11, 5'h05, 5'h0D, 5'h07});
		bypass = 1'b0;
		$display("test_bypass done");
	endtask
	task automatic test_rx();
		int n0;
		n0 = rxclk_n;
		repeat (50) @(posedge clk);
		chk("rxclk rises", 10, rxclk_n - n0);
		rq.delete();
		// line edges kept off the sampling edge
		#1;
		repeat (12) fetpm_mac_model_i.grp(5'h1F);
		fetpm_mac_model_i.grp(5'h18);
		fetpm_mac_model_i.grp(5'h11);
		fetpm_mac_model_i.grp(CT[10]);
		fetpm_mac_model_i.grp(CT[3]);
		chk("crs rx", 1, crs);
		fetpm_mac_model_i.grp(5'h04);
		fetpm_mac_model_i.grp(5'h0D);
		fetpm_mac_model_i.grp(5'h07);
		repeat (3) fetpm_mac_model_i.grp(5'h1F);
		chk("rx nibble count", 5, rq.size());
		chk("rx pre 0", 8'h05, rq[0]);
		chk("rx pre 1", 8'h05, rq[1]);
		chk("rx data a", 8'h0A, rq[2]);
		chk("rx data 3", 8'h03, rq[3]);
		chk("rx error", 1, rq[4][4]);
		chk("crs end", 0, crs);
		$display("test_rx done");
	endtask
	task final_report();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 srst = 1'b0;
		// lets the line monitor lock on idle
		repeat (40) @(posedge clk);
		test_tx();
		test_bypass();
		test_rx();
		final_report();
	end
	initial begin
		#100000;
		num_errors++;
		final_report();
	end
endmodule
`default_nettype wire
